// >>> core/lke_pkg.sv
package lke_pkg;

    // ------------------------------------------------------------
    // legacy i/o ports
    // ------------------------------------------------------------
    localparam logic [15:0] PORT_DATA = 16'h0060;
    localparam logic [15:0] PORT_CMD = 16'h0064;

    // ------------------------------------------------------------
    // memory-mapped operational space
    // ------------------------------------------------------------
    localparam int MEM_ADDR_W = 12;
    localparam logic [11:0] OFS_EMU_STATUS = 12'h10C;
    localparam int STATUS_W = 8;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;
    localparam logic [23:0] RESERVED_ZERO = 24'h000000;

    // ------------------------------------------------------------
    // status layout, bit 7 down to bit 0
    // ------------------------------------------------------------
    typedef struct packed {
        logic parityErr;
        logic timeOut;
        logic auxOutFull;
        logic keyboardInhibitSwitch;
        logic cmdData;
        logic sysFlag;
        logic inFull;
        logic outFull;
    } lke_status_s;

    // ------------------------------------------------------------
    // one legacy i/o access, valid for one cycle
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } lke_io_req_s;

    // ------------------------------------------------------------
    // decoded legacy accesses
    // ------------------------------------------------------------
    typedef struct packed {
        logic wrData;
        logic wrCmd;
        logic rdData;
        logic rdCmd;
    } lke_io_hit_s;

endpackage : lke_pkg

// >>> core/lke_io_decode.sv
`timescale 1ns/1ps
module lke_io_decode
(
    // legacy access
    input wire lke_pkg::lke_io_req_s ioReq,
    input wire logic emulationEnable,
    // decoded strobes
    output lke_pkg::lke_io_hit_s ioHit
);

    // ------------------------------------------------------------
    // port decode, live only while emulation is on
    // ------------------------------------------------------------
    logic isData;
    logic isCmd;

    assign isData = (ioReq.addr == lke_pkg::PORT_DATA);
    assign isCmd = (ioReq.addr == lke_pkg::PORT_CMD);

    assign ioHit.wrData = emulationEnable && ioReq.wr && isData;
    assign ioHit.wrCmd = emulationEnable && ioReq.wr && isCmd;
    assign ioHit.rdData = emulationEnable && ioReq.rd && isData;
    assign ioHit.rdCmd = emulationEnable && ioReq.rd && isCmd;

endmodule : lke_io_decode

// >>> core/lke_irq_select.sv
`timescale 1ns/1ps
module lke_irq_select
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // conditions
    input wire lke_pkg::lke_status_s status,
    input wire logic emulationEnable,
    input wire logic legacyInterruptEnable,
    input wire logic characterPending,
    // interrupt lines
    output logic irqKeyboard,
    output logic irqMouse,
    output logic emulationIrq
);

    // ------------------------------------------------------------
    // legacy lines
    // ------------------------------------------------------------
    logic lineArmed;

    assign lineArmed = emulationEnable && legacyInterruptEnable && status.outFull;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irqKeyboard <= 1'b0;
            irqMouse <= 1'b0;
        end
        else
        begin
            irqMouse <= lineArmed && status.auxOutFull;
            irqKeyboard <= lineArmed && !status.auxOutFull;
        end
    end

    // ------------------------------------------------------------
    // emulation software interrupt
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            emulationIrq <= 1'b0;
        end
        else
        begin
            emulationIrq <= (status.inFull && emulationEnable)
                || (!status.outFull && characterPending);
        end
    end

endmodule : lke_irq_select

// >>> core/lke_status_bank.sv
`timescale 1ns/1ps
module lke_status_bank
#(
    parameter int IO_DATA_W = 8
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // legacy i/o port side
    input wire lke_pkg::lke_io_req_s ioReq,
    input wire logic gateA20Seq,
    input wire logic [7:0] outputData,
    output logic [7:0] ioRdata,
    output logic ioRvalid,
    // memory-mapped side
    input wire logic memWr,
    input wire logic memRd,
    input wire logic [lke_pkg::MEM_ADDR_W-1:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic [31:0] memRdata,
    output logic memRvalid,
    // control bits held elsewhere
    input wire logic emulationEnable,
    input wire logic legacyInterruptEnable,
    input wire logic characterPending,
    // keyboard events
    input wire logic keyboardInhibitSwitch,
    input wire logic parityErrEvt,
    input wire logic timeOutEvt,
    // status and interrupts
    output lke_pkg::lke_status_s legacyEmulationStatus,
    output logic irqKeyboard,
    output logic irqMouse,
    output logic emulationIrq
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (IO_DATA_W != lke_pkg::STATUS_W)
    begin : gBadWidth
        $error("lke_status_bank: IO_DATA_W must equal the status width");
    end

    // ------------------------------------------------------------
    // port decode
    // ------------------------------------------------------------
    lke_pkg::lke_io_hit_s ioHit;

    lke_io_decode uDecode
    (
        .ioReq(ioReq),
        .emulationEnable(emulationEnable),
        .ioHit(ioHit)
    );

    // ------------------------------------------------------------
    // memory write decode
    // ------------------------------------------------------------
    logic memHit;
    logic memWrHit;
    lke_pkg::lke_status_s memWrVal;

    assign memHit = (memAddr == lke_pkg::OFS_EMU_STATUS);
    assign memWrHit = memWr && memHit;
    assign memWrVal = lke_pkg::lke_status_s'(memWdata[lke_pkg::STATUS_W-1:0]);

    // ------------------------------------------------------------
    // inhibit switch change detect
    // ------------------------------------------------------------
    logic switchSeen_q;
    logic switchMoved;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            switchSeen_q <= 1'b0;
        end
        else
        begin
            switchSeen_q <= keyboardInhibitSwitch;
        end
    end

    assign switchMoved = (switchSeen_q != keyboardInhibitSwitch);

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    lke_pkg::lke_status_s status_q;
    lke_pkg::lke_status_s status_d;

    always_comb
    begin
        status_d = status_q;
        if (memWrHit)
        begin
            status_d = memWrVal;
        end
        if (ioHit.wrData)
        begin
            status_d.cmdData = 1'b0;
        end
        if (ioHit.wrCmd)
        begin
            status_d.cmdData = 1'b1;
        end
        if ((ioHit.wrData || ioHit.wrCmd) && !gateA20Seq)
        begin
            status_d.inFull = 1'b1;
        end
        if (ioHit.rdData)
        begin
            status_d.outFull = 1'b0;
        end
        if (switchMoved)
        begin
            status_d.keyboardInhibitSwitch = keyboardInhibitSwitch;
        end
        if (parityErrEvt)
        begin
            status_d.parityErr = 1'b1;
        end
        if (timeOutEvt)
        begin
            status_d.timeOut = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            status_q <= lke_pkg::lke_status_s'(lke_pkg::STATUS_RESET);
        end
        else
        begin
            status_q <= status_d;
        end
    end

    assign legacyEmulationStatus = status_q;

    // ------------------------------------------------------------
    // memory read path, free of side effects
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            memRdata <= lke_pkg::RDATA_UNMAPPED;
            memRvalid <= 1'b0;
        end
        else
        begin
            memRvalid <= memRd;
            if (memRd && memHit)
            begin
                memRdata <= {lke_pkg::RESERVED_ZERO, status_q};
            end
            else
            begin
                memRdata <= lke_pkg::RDATA_UNMAPPED;
            end
        end
    end

    // ------------------------------------------------------------
    // legacy read path
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ioRdata <= lke_pkg::STATUS_RESET;
            ioRvalid <= 1'b0;
        end
        else
        begin
            ioRvalid <= ioHit.rdCmd || ioHit.rdData;
            if (ioHit.rdCmd)
            begin
                ioRdata <= status_q;
            end
            else if (ioHit.rdData)
            begin
                ioRdata <= outputData;
            end
            else
            begin
                ioRdata <= lke_pkg::STATUS_RESET;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt lines
    // ------------------------------------------------------------
    lke_irq_select uIrq
    (
        .mclk(mclk),
        .rst(rst),
        .status(status_q),
        .emulationEnable(emulationEnable),
        .legacyInterruptEnable(legacyInterruptEnable),
        .characterPending(characterPending),
        .irqKeyboard(irqKeyboard),
        .irqMouse(irqMouse),
        .emulationIrq(emulationIrq)
    );

endmodule : lke_status_bank

// >>> bench/lke_status_bank_props.sv
`timescale 1ns/1ps
module lke_status_bank_props
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // watched ports
    input wire lke_pkg::lke_io_req_s ioReq,
    input wire logic gateA20Seq,
    input wire logic emulationEnable,
    input wire logic legacyInterruptEnable,
    input wire logic characterPending,
    input wire logic parityErrEvt,
    input wire logic timeOutEvt,
    input wire lke_pkg::lke_status_s legacyEmulationStatus,
    input wire logic ioRvalid,
    input wire logic [7:0] ioRdata,
    input wire logic irqKeyboard,
    input wire logic irqMouse,
    input wire logic emulationIrq
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    lke_pkg::lke_status_s st;
    logic ee, wrD, wrC, rdD, rdC;
    assign st = legacyEmulationStatus;
    assign ee = emulationEnable;
    assign wrD = ioReq.wr && ioReq.addr == lke_pkg::PORT_DATA && ee;
    assign wrC = ioReq.wr && ioReq.addr == lke_pkg::PORT_CMD && ee;
    assign rdD = ioReq.rd && ioReq.addr == lke_pkg::PORT_DATA && ee;
    assign rdC = ioReq.rd && ioReq.addr == lke_pkg::PORT_CMD && ee;
    property p_cmd;
        wrD || wrC |=> st.cmdData == $past(wrC);
    endproperty
    a_cmd: assert property (p_cmd) else $error("cmd bit wrong");
    property p_in;
        (wrD || wrC) && !gateA20Seq |=> st.inFull;
    endproperty
    a_in: assert property (p_in) else $error("input full not set");
    property p_out;
        rdD |=> !st.outFull;
    endproperty
    a_out: assert property (p_out) else $error("output full kept");
    property p_ein;
        st.inFull && ee |=> emulationIrq;
    endproperty
    a_ein: assert property (p_ein) else $error("no input irq");
    property p_ecp;
        !st.outFull && characterPending |=> emulationIrq;
    endproperty
    a_ecp: assert property (p_ecp) else $error("no pending irq");
    property p_sel;
        st.outFull && legacyInterruptEnable && ee
            |=> {irqMouse, irqKeyboard} == {$past(st.auxOutFull), !$past(st.auxOutFull)};
    endproperty
    a_sel: assert property (p_sel) else $error("wrong line");
    property p_rdc;
        rdC |=> ioRvalid && ioRdata == $past(st);
    endproperty
    a_rdc: assert property (p_rdc) else $error("bad status read");
    property p_off;
        !ee |=> !ioRvalid;
    endproperty
    a_off: assert property (p_off) else $error("read while off");
    property p_par;
        parityErrEvt |=> st.parityErr;
    endproperty
    a_par: assert property (p_par) else $error("parity bit not set");
    property p_tmo;
        timeOutEvt |=> st.timeOut;
    endproperty
    a_tmo: assert property (p_tmo) else $error("time-out bit not set");
endmodule : lke_status_bank_props
bind lke_status_bank lke_status_bank_props props (.*);

// >>> bench/lke_app_sw.sv
`timescale 1ns/1ps
module lke_app_sw
(
    // clock
    input wire logic mclk,
    // legacy access
    output lke_pkg::lke_io_req_s ioReq,
    output logic gateA20Seq
);
    initial
    begin
        ioReq = '0;
        gateA20Seq = 1'h0;
    end
    // one-cycle access, lines scrambled once released
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input logic g);
        @(negedge mclk);
        ioReq = {w, !w, a, d};
        gateA20Seq = g;
        @(negedge mclk);
        ioReq = {2'h0, ~a, ~d};
        gateA20Seq = !g;
    endtask : io
endmodule : lke_app_sw

// >>> bench/tb_lke_status_bank.sv
`timescale 1ns/1ps
module tb_lke_status_bank;
    localparam logic [11:0] OFS = lke_pkg::OFS_EMU_STATUS;
    localparam logic [15:0] PD = lke_pkg::PORT_DATA;
    localparam logic [15:0] PC = lke_pkg::PORT_CMD;
    logic mclk, rst, gateA20Seq, memWr, memRd, ioRvalid, memRvalid;
    logic emulationEnable, legacyInterruptEnable, characterPending;
    logic keyboardInhibitSwitch, parityErrEvt, timeOutEvt;
    logic irqKeyboard, irqMouse, emulationIrq;
    logic [7:0] outputData, ioRdata, es;
    logic [11:0] memAddr;
    logic [31:0] memWdata, memRdata;
    lke_pkg::lke_io_req_s ioReq;
    lke_pkg::lke_status_s legacyEmulationStatus;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 52034;
    lke_status_bank dut (.*);
    lke_app_sw sw (.*);
    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    function automatic logic [7:0] after_io(input logic [7:0] s, input logic w,
        input logic [15:0] a, input logic g);
        lke_pkg::lke_status_s t;
        t = s;
        if (w)
        begin
            t.cmdData = a == PC;
            t.inFull = t.inFull | !g;
        end
        else if (a == PD)
            t.outFull = 1'h0;
        return t;
    endfunction : after_io
    task automatic mem(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge mclk);
        {memWr, memRd, memAddr} = {w, !w, a};
        memWdata = {lke_pkg::RESERVED_ZERO, d};
        @(negedge mclk);
        {memWr, memRd} = 2'h0;
        if (w && a == OFS)
            es = d;
        chk("memRvalid", !w, memRvalid);
        if (!w)
            chk("memRdata", a == OFS ? {24'h0, es} : 32'h0, memRdata);
        chk("status", es, legacyEmulationStatus);
    endtask : mem
    task automatic io(input logic w, input logic [15:0] a, input logic g);
        outputData = 8'($random(seed));
        sw.io(w, a, 8'($random(seed)), g);
        if (!w && emulationEnable)
            chk("ioRdata", a == PD ? outputData : es, ioRdata);
        chk("ioRvalid", !w && emulationEnable, ioRvalid);
        if (emulationEnable)
            es = after_io(es, w, a, g);
        chk("status", es, legacyEmulationStatus);
    endtask : io
    task automatic irqs(input logic [2:0] e);
        @(negedge mclk);
        chk("irqs", e, {irqMouse, irqKeyboard, emulationIrq});
    endtask : irqs
    initial
    begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        rst = 1'h1;
        {memWr, memRd, memAddr, memWdata, outputData, parityErrEvt, timeOutEvt} = '0;
        {legacyInterruptEnable, characterPending, keyboardInhibitSwitch} = '0;
        emulationEnable = 1'h1;
        es = 8'h00;
        repeat (2) @(negedge mclk);
        rst = 1'h0;
        chk("status", es, legacyEmulationStatus);
        for (int i = 0; i < 5; i++)
        begin
            mem(1'h1, OFS, i == 0 ? 8'hFF : 8'($random(seed)));
            mem(1'h0, OFS, 8'h00);
        end
        mem(1'h1, 12'h104, 8'h5A);
        mem(1'h0, 12'h108, 8'h00);
        mem(1'h1, OFS, 8'h01);
        io(1'h0, PC, 1'h0);
        io(1'h0, PD, 1'h0);
        io(1'h1, PD, 1'h1);
        io(1'h1, PC, 1'h0);
        io(1'h1, PD, 1'h0);
        repeat (20)
            io(1'($random(seed)), 1'($random(seed)) ? PC : PD, 1'($random(seed)));
        legacyInterruptEnable = 1'h1;
        mem(1'h1, OFS, 8'h21);
        irqs(3'h4);
        mem(1'h1, OFS, 8'h03);
        irqs(3'h3);
        characterPending = 1'h1;
        mem(1'h1, OFS, 8'h00);
        irqs(3'h1);
        emulationEnable = 1'h0;
        mem(1'h1, OFS, 8'h23);
        irqs(3'h0);
        io(1'h1, PD, 1'h0);
        io(1'h0, PC, 1'h0);
        emulationEnable = 1'h1;
        mem(1'h1, OFS, 8'h04);
        {parityErrEvt, timeOutEvt, keyboardInhibitSwitch} = 3'h7;
        @(negedge mclk);
        {parityErrEvt, timeOutEvt} = 2'h0;
        repeat (2) @(negedge mclk);
        chk("status", 8'hD4, legacyEmulationStatus);
        keyboardInhibitSwitch = 1'h0;
        repeat (3) @(negedge mclk);
        chk("status", 8'hC4, legacyEmulationStatus);
        // mid-run reset must clear a busy status
        rst = 1'h1;
        repeat (2) @(negedge mclk);
        rst = 1'h0;
        es = 8'h00;
        chk("status", es, legacyEmulationStatus);
        chk("irqs", 3'h0, {irqMouse, irqKeyboard, emulationIrq});
        irqs(3'h1);
        tally_and_finish();
    end
endmodule : tb_lke_status_bank
